// ---- hw/dppia_pkg.sv ----
package dppia_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register selection, coded as {select_high, select_low}
    localparam logic [1:0] SEL_A_DATA = 2'h0;
    localparam logic [1:0] SEL_A_CTRL = 2'h1;
    localparam logic [1:0] SEL_B_DATA = 2'h2;
    localparam logic [1:0] SEL_B_CTRL = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int CTL_FLAG1_BIT      = 7;
    localparam int CTL_FLAG2_BIT      = 6;
    localparam int CTL_EDGE2_BIT      = 4;
    localparam int CTL_EN2_BIT        = 3;
    localparam int CTL_DIR_ACCESS_BIT = 2;
    localparam int CTL_EDGE1_BIT      = 1;
    localparam int CTL_EN1_BIT        = 0;
    localparam logic [7:0] CTL_WRITE_MASK = 8'h3f;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] CONTROL_RESET   = 8'h00;
    localparam logic [7:0] DIRECTION_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET     = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_READ,
        BUS_WRITE
    } dppia_bus_e;

endpackage

// ---- hw/dppia_sync.sv ----
`timescale 1ns/1ps
module dppia_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    import dppia_pkg::*;

    logic [WIDTH-1:0] meta_ff;

    // A zero-width stage has nothing to carry
    if (WIDTH < 1) begin : g_bad_width
        $error("dppia_sync: WIDTH must be at least 1");
    end

    // First stage feeds only the second, nothing else looks at it
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_ff <= '0;
            o_sync  <= '0;
        end else begin
            meta_ff <= i_async;
            o_sync  <= meta_ff;
        end
    end
endmodule // dppia_sync

// ---- hw/dppia_edge.sv ----
`timescale 1ns/1ps
module dppia_edge (
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    input  wire logic i_level,
    input  wire logic i_rising_sel,
    output logic      o_event
);
    import dppia_pkg::*;

    logic prev_ff;
    logic primed_ff;

    // First sample after reset only primes, so a high line is no false edge
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_ff   <= 1'b0;
            primed_ff <= 1'b0;
        end else begin
            prev_ff   <= i_level;
            primed_ff <= 1'b1;
        end
    end

    // R18: one pulse per edge
    assign o_event = primed_ff && (i_rising_sel ? (i_level && !prev_ff) : (!i_level && prev_ff));
endmodule // dppia_edge

// ---- hw/dppia_top.sv ----
// What this block does
// R1: Selects 00 pick side A port data or direction by access bit; 01 side A control.
// R2: Selects 10 pick side B port data or direction by access bit; 11 side B control.
// R3: Side B port read returns latch bits for outputs, pin levels for inputs.
// R4: One active-low open-drain request output per side, wired-OR capable.
// R5: Flags sit at control bits 6 and 7, each gated by its own enable.
// R6: Active edge on side A first control input always sets bit 7.
// R7: Side A request pulls low while bit 7 and bit 0 are both set.
// R8: Side A second control input edge sets bit 6; requests with bit 3.
// R9: Side A port data read clears side A bits 6 and 7.
// R10: Side B flags and enables behave exactly as side A.
// R11: Side B port data read clears side B bits 6 and 7.
// R12: Direction bit 1 makes a port line output, 0 makes it input.
// R13: Side B input lines have their drivers disabled.
// R14: Side A port read returns pin levels on all eight lines.
// R15: Access only while both high selects high and low select low.
// R16: Write data latched during phase two high, stored after it falls.
// R17: Control bit 1 picks first control input edge: 0 falling, 1 rising.
// R18: Control inputs are synchronised and edges detected once each.
// R19: Reset clears all registers: lines inputs, requests released.
`timescale 1ns/1ps
module dppia_top (
    input  wire logic       i_clock,
    input  wire logic       i_reset_n,
    // Processor side
    input  wire logic       i_phase2,
    input  wire logic       i_chip_sel_hi_first,
    input  wire logic       i_chip_sel_hi_second,
    input  wire logic       i_chip_sel_low_n,
    input  wire logic       i_select_low,
    input  wire logic       i_select_high,
    input  wire logic       i_read,
    input  wire logic [7:0] i_data,
    output logic      [7:0] o_data,
    output logic            o_data_oe,
    input  wire logic       i_side_a_request_n,
    output logic            o_side_a_request_n,
    output logic            o_side_a_request_n_oe,
    input  wire logic       i_side_b_request_n,
    output logic            o_side_b_request_n,
    output logic            o_side_b_request_n_oe,
    // Peripheral side
    input  wire logic [7:0] i_side_a_pins,
    output logic      [7:0] o_side_a_pins,
    output logic      [7:0] o_side_a_pins_oe,
    input  wire logic [7:0] i_side_b_pins,
    output logic      [7:0] o_side_b_pins,
    output logic      [7:0] o_side_b_pins_oe,
    input  wire logic       i_side_a_ctl_in1,
    input  wire logic       i_side_a_ctl_io2,
    input  wire logic       i_side_b_ctl_in1,
    input  wire logic       i_side_b_ctl_io2
);
    import dppia_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic [SYNC_STAGES-1:0] rst_pipe_ff;
    logic                   rst_n;

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_pipe_ff <= '0;
        end else begin
            rst_pipe_ff <= {rst_pipe_ff[SYNC_STAGES-2:0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_ff[SYNC_STAGES-1];

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [14:0] bus_s;
    logic [7:0]  pins_a_s;
    logic [7:0]  pins_b_s;
    logic [3:0]  ctl_s;

    dppia_sync #(.WIDTH(15)) u_sync_bus (
        .i_clock (i_clock),
        .i_rst_n (rst_n),
        .i_async ({i_phase2, i_chip_sel_hi_first, i_chip_sel_hi_second, i_chip_sel_low_n,
                   i_select_high, i_select_low, i_read, i_data}),
        .o_sync  (bus_s)
    );

    dppia_sync #(.WIDTH(8)) u_sync_pins_a (
        .i_clock (i_clock),
        .i_rst_n (rst_n),
        .i_async (i_side_a_pins),
        .o_sync  (pins_a_s)
    );

    dppia_sync #(.WIDTH(8)) u_sync_pins_b (
        .i_clock (i_clock),
        .i_rst_n (rst_n),
        .i_async (i_side_b_pins),
        .o_sync  (pins_b_s)
    );

    // R18: control inputs through two flops
    dppia_sync #(.WIDTH(4)) u_sync_ctl (
        .i_clock (i_clock),
        .i_rst_n (rst_n),
        .i_async ({i_side_b_ctl_io2, i_side_b_ctl_in1, i_side_a_ctl_io2, i_side_a_ctl_in1}),
        .o_sync  (ctl_s)
    );

    logic       phase2_s;
    logic       selected;
    logic [1:0] sel_s;
    logic       read_s;
    logic [7:0] data_s;

    assign phase2_s = bus_s[14];
    // R15: chip select decode
    assign selected = bus_s[13] && bus_s[12] && !bus_s[11];
    assign sel_s    = bus_s[10:9];
    assign read_s   = bus_s[8];
    assign data_s   = bus_s[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle tracking
    dppia_bus_e bus_state_ff;
    logic [1:0] addr_ff;
    logic [7:0] wdata_ff;
    logic       phase2_fall;

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_state_ff <= BUS_IDLE;
            addr_ff      <= 2'h0;
        end else begin
            case (bus_state_ff)
                BUS_IDLE: begin
                    if (phase2_s && selected) begin
                        bus_state_ff <= read_s ? BUS_READ : BUS_WRITE;
                        addr_ff      <= sel_s;
                    end
                end
                BUS_READ, BUS_WRITE: begin
                    if (!phase2_s) begin
                        bus_state_ff <= BUS_IDLE;
                    end
                end
                default: bus_state_ff <= BUS_IDLE;
            endcase
        end
    end

    assign phase2_fall = (bus_state_ff != BUS_IDLE) && !phase2_s;

    // R16: hold the data seen while phase two is high
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            wdata_ff <= 8'h00;
        end else if (bus_state_ff == BUS_WRITE && phase2_s) begin
            wdata_ff <= data_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-side registers
    logic [7:0] ctrl_ff  [2];
    logic [7:0] dir_ff   [2];
    logic [7:0] latch_ff [2];
    logic [1:0] ev1;
    logic [1:0] ev2;
    logic [1:0] port_read_done;
    logic [1:0] req;
    logic [7:0] pins_s   [2];
    logic [7:0] port_view[2];

    assign pins_s[0] = pins_a_s;
    assign pins_s[1] = pins_b_s;
    // R14: side A reads pins on every line
    assign port_view[0] = pins_s[0];
    // R3: side B reads latch on outputs, pins on inputs
    assign port_view[1] = (latch_ff[1] & dir_ff[1]) | (pins_s[1] & ~dir_ff[1]);

    for (genvar s = 0; s < 2; s++) begin : g_side
        logic wr_data;
        logic wr_ctrl;
        logic dir_access;

        assign dir_access = ctrl_ff[s][CTL_DIR_ACCESS_BIT];
        assign wr_data    = phase2_fall && bus_state_ff == BUS_WRITE && addr_ff == 2'(2*s);
        assign wr_ctrl    = phase2_fall && bus_state_ff == BUS_WRITE && addr_ff == 2'(2*s+1);
        // R9: port read is a read of the data slot with access bit set
        // R11: same for side B
        assign port_read_done[s] = phase2_fall && bus_state_ff == BUS_READ
                                   && addr_ff == 2'(2*s) && dir_access;

        // R17: first control input edge chosen by bit 1
        dppia_edge u_edge1 (
            .i_clock      (i_clock),
            .i_rst_n      (rst_n),
            .i_level      (ctl_s[2*s]),
            .i_rising_sel (ctrl_ff[s][CTL_EDGE1_BIT]),
            .o_event      (ev1[s])
        );

        dppia_edge u_edge2 (
            .i_clock      (i_clock),
            .i_rst_n      (rst_n),
            .i_level      (ctl_s[2*s+1]),
            .i_rising_sel (ctrl_ff[s][CTL_EDGE2_BIT]),
            .o_event      (ev2[s])
        );

        // R1: data slot goes to latch or direction by access bit
        // R2: side B decodes the same way
        // R19: cleared at reset
        always_ff @(posedge i_clock or negedge rst_n) begin
            if (!rst_n) begin
                latch_ff[s] <= LATCH_RESET;
                dir_ff[s]   <= DIRECTION_RESET;
            end else if (wr_data) begin
                if (dir_access) begin
                    latch_ff[s] <= wdata_ff;
                end else begin
                    dir_ff[s] <= wdata_ff;
                end
            end
        end

        // Writable control bits
        always_ff @(posedge i_clock or negedge rst_n) begin
            if (!rst_n) begin
                ctrl_ff[s][5:0] <= CONTROL_RESET[5:0];
            end else if (wr_ctrl) begin
                ctrl_ff[s][5:0] <= wdata_ff[5:0] & CTL_WRITE_MASK[5:0];
            end
        end

        // R6: edge sets bit 7 regardless of enable; set beats clear
        // R10: side B flags alike
        always_ff @(posedge i_clock or negedge rst_n) begin
            if (!rst_n) begin
                ctrl_ff[s][CTL_FLAG1_BIT] <= CONTROL_RESET[CTL_FLAG1_BIT];
            end else if (ev1[s]) begin
                ctrl_ff[s][CTL_FLAG1_BIT] <= 1'b1;
            end else if (port_read_done[s]) begin
                ctrl_ff[s][CTL_FLAG1_BIT] <= 1'b0;
            end
        end

        // R8: second input edge sets bit 6
        always_ff @(posedge i_clock or negedge rst_n) begin
            if (!rst_n) begin
                ctrl_ff[s][CTL_FLAG2_BIT] <= CONTROL_RESET[CTL_FLAG2_BIT];
            end else if (ev2[s]) begin
                ctrl_ff[s][CTL_FLAG2_BIT] <= 1'b1;
            end else if (port_read_done[s]) begin
                ctrl_ff[s][CTL_FLAG2_BIT] <= 1'b0;
            end
        end

        // R5: each flag gated by its own enable
        // R7: bit 7 with bit 0
        assign req[s] = (ctrl_ff[s][CTL_FLAG1_BIT] && ctrl_ff[s][CTL_EN1_BIT])
                     || (ctrl_ff[s][CTL_FLAG2_BIT] && ctrl_ff[s][CTL_EN2_BIT]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    logic [1:0] req_oe_ff;
    logic [7:0] rdata;

    // R4: open drain, only ever pulls low
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            req_oe_ff <= 2'h0;
        end else begin
            req_oe_ff <= req;
        end
    end
    assign o_side_a_request_n    = 1'b0;
    assign o_side_a_request_n_oe = req_oe_ff[0];
    assign o_side_b_request_n    = 1'b0;
    assign o_side_b_request_n_oe = req_oe_ff[1];

    // R12: direction bit 1 drives the line
    // R13: side B inputs left undriven
    assign o_side_a_pins    = latch_ff[0];
    assign o_side_a_pins_oe = dir_ff[0];
    assign o_side_b_pins    = latch_ff[1];
    assign o_side_b_pins_oe = dir_ff[1];

    always_comb begin
        case (addr_ff)
            SEL_A_DATA: rdata = ctrl_ff[0][CTL_DIR_ACCESS_BIT] ? port_view[0] : dir_ff[0];
            SEL_A_CTRL: rdata = ctrl_ff[0];
            SEL_B_DATA: rdata = ctrl_ff[1][CTL_DIR_ACCESS_BIT] ? port_view[1] : dir_ff[1];
            SEL_B_CTRL: rdata = ctrl_ff[1];
            default:    rdata = 8'h00;
        endcase
    end

    // Refreshed every cycle of the read, so late pin changes still reach the bus
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_data <= 8'h00;
        end else if (bus_state_ff == BUS_READ) begin
            o_data <= rdata;
        end
    end
    assign o_data_oe = (bus_state_ff == BUS_READ) && phase2_s;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!rst_n);

    sequence s_a_port_read;
        port_read_done[0] && !ev1[0] && !ev2[0];
    endsequence

    sequence s_b_port_read;
        port_read_done[1] && !ev1[1] && !ev2[1];
    endsequence

    AST_A_EDGE1_SETS: assert property (ev1[0] |=> ctrl_ff[0][CTL_FLAG1_BIT]) // R6
        else $error("Side A flag 7 not set by edge");
    AST_A_EDGE2_SETS: assert property (ev2[0] |=> ctrl_ff[0][CTL_FLAG2_BIT]) // R8
        else $error("Side A flag 6 not set by edge");
    AST_B_EDGE_SETS: assert property (ev1[1] || ev2[1] |=> ctrl_ff[1][CTL_FLAG1_BIT] || ctrl_ff[1][CTL_FLAG2_BIT]) // R10
        else $error("Side B flag not set by edge");
    AST_A_READ_CLEARS: assert property (s_a_port_read |=> ctrl_ff[0][7:6] == 2'h0) // R9
        else $error("Side A flags not cleared by port read");
    AST_B_READ_CLEARS: assert property (s_b_port_read |=> ctrl_ff[1][7:6] == 2'h0) // R11
        else $error("Side B flags not cleared by port read");
    AST_A_REQ_FOLLOWS: assert property (req[0] != $past(req[0]) |=> o_side_a_request_n_oe == $past(req[0])) // R7
        else $error("Side A request does not follow flags");
    AST_A_REQ_MASKED: assert property (!ctrl_ff[0][CTL_EN1_BIT] && !ctrl_ff[0][CTL_EN2_BIT] ##1
                                       !ctrl_ff[0][CTL_EN1_BIT] && !ctrl_ff[0][CTL_EN2_BIT]
                                       |-> !o_side_a_request_n_oe) // R5
        else $error("Side A request with both enables clear");
    AST_REQ_DRIVES_LOW: assert property (o_side_a_request_n_oe || o_side_b_request_n_oe |-> !o_side_a_request_n && !o_side_b_request_n) // R4
        else $error("Request output driven high");
    AST_B_PIN_DRIVE: assert property (o_side_b_pins_oe == dir_ff[1]) // R13
        else $error("Side B driver enable differs from direction");
    AST_NO_ACCESS_UNSELECTED: assert property (bus_state_ff == BUS_IDLE && !selected |=> bus_state_ff == BUS_IDLE) // R15
        else $error("Access started without chip select");
    AST_WRITE_AFTER_FALL: assert property (bus_state_ff == BUS_WRITE && !phase2_s && addr_ff == SEL_A_CTRL
                                           |=> ctrl_ff[0][5:0] == $past(wdata_ff[5:0])) // R16
        else $error("Control write not stored after phase two fall");
    AST_B_READBACK: assert property (bus_state_ff == BUS_READ && addr_ff == SEL_B_DATA
                                     && ctrl_ff[1][CTL_DIR_ACCESS_BIT] |=> o_data == $past(port_view[1])) // R3
        else $error("Side B read data wrong");
endmodule // dppia_top

// ---- tb/dppia_periph.sv ----
`timescale 1ns/1ps
module dppia_periph (
    input  wire logic       i_clock,
    input  wire logic [7:0] i_a_out,
    input  wire logic [7:0] i_a_oe,
    input  wire logic [7:0] i_b_out,
    input  wire logic [7:0] i_b_oe,
    input  wire logic [7:0] i_a_drive,
    input  wire logic [7:0] i_a_drive_en,
    input  wire logic [7:0] i_b_drive,
    input  wire logic [7:0] i_b_drive_en,
    input  wire logic [7:0] i_load,
    input  wire logic       i_req_a_oe,
    input  wire logic       i_req_b_oe,
    output logic      [7:0] o_a_level,
    output logic      [7:0] o_b_level,
    output logic            o_req_a_n,
    output logic            o_req_b_n
);
    logic [7:0] float_ff = 8'h55;

    ////////////////////////////////////////////////////////////////////////////
    // Undriven side B lines toggle, so a stale level never reads back as valid
    always_ff @(posedge i_clock) begin
        float_ff <= ~float_ff;
    end

    ////////////////////////////////////////////////////////////////////////////
    // device drive wins, side A pulled up, load sinks a line low
    assign o_a_level = ((i_a_oe & i_a_out) | (~i_a_oe & i_a_drive_en & i_a_drive) | (~i_a_oe & ~i_a_drive_en))
                       & ~i_load;
    assign o_b_level = ((i_b_oe & i_b_out) | (~i_b_oe & i_b_drive_en & i_b_drive)
                       | (~i_b_oe & ~i_b_drive_en & float_ff)) & ~i_load;

    ////////////////////////////////////////////////////////////////////////////
    // open-drain request with external pull-up
    assign o_req_a_n = ~i_req_a_oe;
    assign o_req_b_n = ~i_req_b_oe;
endmodule // dppia_periph

// ---- tb/tb_dppia_top.sv ----
`timescale 1ns/1ps
module tb_dppia_top;
    import dppia_pkg::*;
    localparam int LIMIT = 8000;
    logic       clk = 1'b0, rst_n = 1'b1;
    logic       p2 = 1'b0, cs1 = 1'b1, cs2 = 1'b1, cs3n = 1'b0, sl = 1'b0, sh = 1'b0, rd = 1'b0;
    logic [7:0] wd = 8'h00, od, pa_o, pa_oe, pb_o, pb_oe, pa_lv, pb_lv, rdat;
    logic [7:0] drv_a = 8'h00, en_a = 8'h0a, drv_b = 8'h96, en_b = 8'hff, load = 8'h04;
    logic       doe, ra_n, rb_n, ra_oe, rb_oe, ra_lv, rb_lv;
    logic [1:0] ctl1 = 2'b00, ctl2 = 2'b00;
    int         failures = 0, n_compared = 0, cycles = 0, bad = 0;
    localparam logic [17:0] ROWS [8] = '{
        {SEL_A_CTRL, 8'h00, 8'h00}, {SEL_A_DATA, 8'ha5, 8'ha5}, {SEL_B_CTRL, 8'h00, 8'h00},
        {SEL_B_DATA, 8'h3c, 8'h3c}, {SEL_A_CTRL, 8'hff, 8'h3f}, {SEL_B_CTRL, 8'hff, 8'h3f},
        {SEL_A_CTRL, 8'h04, 8'h04}, {SEL_B_CTRL, 8'h04, 8'h04}};

    always #12.5 clk = ~clk;

    dppia_top u_dppia_top (
        .i_clock(clk), .i_reset_n(rst_n), .i_phase2(p2), .i_chip_sel_hi_first(cs1),
        .i_chip_sel_hi_second(cs2), .i_chip_sel_low_n(cs3n), .i_select_low(sl), .i_select_high(sh),
        .i_read(rd), .i_data(wd), .o_data(od), .o_data_oe(doe), .i_side_a_request_n(ra_lv),
        .o_side_a_request_n(ra_n), .o_side_a_request_n_oe(ra_oe), .i_side_b_request_n(rb_lv),
        .o_side_b_request_n(rb_n), .o_side_b_request_n_oe(rb_oe), .i_side_a_pins(pa_lv),
        .o_side_a_pins(pa_o), .o_side_a_pins_oe(pa_oe), .i_side_b_pins(pb_lv), .o_side_b_pins(pb_o),
        .o_side_b_pins_oe(pb_oe), .i_side_a_ctl_in1(ctl1[0]), .i_side_a_ctl_io2(ctl2[0]),
        .i_side_b_ctl_in1(ctl1[1]), .i_side_b_ctl_io2(ctl2[1]));

    dppia_periph u_dppia_periph (
        .i_clock(clk), .i_a_out(pa_o), .i_a_oe(pa_oe), .i_b_out(pb_o), .i_b_oe(pb_oe),
        .i_a_drive(drv_a), .i_a_drive_en(en_a), .i_b_drive(drv_b), .i_b_drive_en(en_b),
        .i_load(load), .i_req_a_oe(ra_oe), .i_req_b_oe(rb_oe), .o_a_level(pa_lv),
        .o_b_level(pb_lv), .o_req_a_n(ra_lv), .o_req_b_n(rb_lv));

    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            close_out();
        end
    end

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    // Phase two high and low 8 clocks each, well above the 3-clock minimum
    task automatic bus(input logic rd_i, input logic [1:0] sel, input logic [7:0] wdat);
        @(posedge clk);
        #1;
        {sh, sl} = sel;
        rd = rd_i;
        wd = wdat;
        // selects held through the whole access
        cs1 = (bad != 1);
        cs2 = (bad != 2);
        cs3n = (bad == 3);
        p2 = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        rdat = od;
        chk1("data oe in access", rd_i, doe);
        p2 = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk1("data oe after access", 1'b0, doe);
    endtask

    task automatic rd_chk(input string what, input logic [1:0] sel, input logic [7:0] exp);
        bus(1'b1, sel, 8'h00);
        chk8(what, exp, rdat);
    endtask

    task automatic settle();
        repeat (8) @(posedge clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [1:0] cs_sel;
        logic [1:0] ds_sel;
        logic       req;
        // Reset falls after time zero so every flop sees its edge before the first clock
        #1;
        rst_n = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        chk8("pins oe in reset", 8'h00, pa_oe | pb_oe);
        rst_n = 1'b1;
        settle();
        for (int k = 0; k < 4; k++) begin
            rd_chk("reg after reset", 2'(k), 8'h00);
        end
        chk1("requests after reset", 1'b1, ra_lv & rb_lv);
        $display("test reset done");

        for (int r = 0; r < 8; r++) begin
            bus(1'b0, ROWS[r][17:16], ROWS[r][15:8]);
            rd_chk("register row", ROWS[r][17:16], ROWS[r][7:0]);
        end
        $display("test register table done");

        for (bad = 1; bad <= 3; bad++) begin
            bus(1'b0, SEL_A_CTRL, 8'h1b);
        end
        bad = 0;
        rd_chk("deselected write", SEL_A_CTRL, 8'h04);
        $display("test chip select done");

        bus(1'b0, SEL_A_DATA, 8'h0f);
        bus(1'b0, SEL_B_DATA, 8'h0f);
        chk8("a drive enables", 8'ha5, pa_oe);
        chk8("b drive enables", 8'h3c, pb_oe);
        chk8("a latch", 8'h0f, pa_o);
        chk8("b latch", 8'h0f, pb_o);
        rd_chk("a port read", SEL_A_DATA, 8'h51);
        rd_chk("b port read", SEL_B_DATA, 8'h8e);
        $display("test port read done");

        for (int s = 0; s < 2; s++) begin
            cs_sel = s ? SEL_B_CTRL : SEL_A_CTRL;
            ds_sel = s ? SEL_B_DATA : SEL_A_DATA;
            bus(1'b0, cs_sel, 8'h1f);
            ctl1[s] = 1'b1;
            settle();
            req = s ? rb_lv : ra_lv;
            chk1("req first flag", 1'b0, req);
            rd_chk("ctrl first flag", cs_sel, 8'h9f);
            bus(1'b0, cs_sel, 8'h1e);
            req = s ? rb_lv : ra_lv;
            chk1("req first masked", 1'b1, req);
            rd_chk("ctrl flag kept", cs_sel, 8'h9e);
            ctl2[s] = 1'b1;
            settle();
            req = s ? rb_lv : ra_lv;
            chk1("req second flag", 1'b0, req);
            rd_chk("ctrl both flags", cs_sel, 8'hde);
            bus(1'b1, ds_sel, 8'h00);
            rd_chk("ctrl after port read", cs_sel, 8'h1e);
            req = s ? rb_lv : ra_lv;
            chk1("req after port read", 1'b1, req);
            bus(1'b0, cs_sel, 8'h04);
            ctl1[s] = 1'b0;
            ctl2[s] = 1'b0;
            settle();
            rd_chk("falling edges", cs_sel, 8'hc4);
            req = s ? rb_lv : ra_lv;
            chk1("req both disabled", 1'b1, req);
            bus(1'b1, ds_sel, 8'h00);
            ctl1[s] = 1'b1;
            ctl2[s] = 1'b1;
            settle();
            rd_chk("rising ignored", cs_sel, 8'h04);
            $display("test flags side %0d done", s);
        end
        chk1("request pin drive level", 1'b0, ra_n | rb_n);

        // Second reset in mid-run must release everything again
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk8("oe in second reset", 8'h00, pa_oe | pb_oe | {6'h00, ra_oe, rb_oe});
        rst_n = 1'b1;
        settle();
        rd_chk("ctrl after second reset", SEL_A_CTRL, 8'h00);
        $display("test second reset done");
        close_out();
    end
endmodule // tb_dppia_top
